/* File: hdl/pev_regs.vh */
// constants for the privileged entry vectoring block
`ifndef PEV_REGS_VH
`define PEV_REGS_VH

// ***********************************************
// register offsets on the plain register port
// ***********************************************
`define PEV_ADDR_W 8
`define PEV_OFF_BASE 8'h00
`define PEV_OFF_FETCH_CTL 8'h08
`define PEV_OFF_MODE 8'h10
`define PEV_OFF_FCS_VIS 8'h18
`define PEV_OFF_EXC_ADDR 8'h20
`define PEV_OFF_STATUS 8'h28
`define PEV_OFF_FCS_FIRST 8'h30

// ***********************************************
// field positions and reset values
// ***********************************************
`define PEV_CTL_SHADOW_BIT 1
`define PEV_CTL_HWINSTR_BIT 2
`define PEV_BASE_RESET 64'h0000000000000000
`define PEV_FCS_RESET 64'h0000000000000000
`define PEV_MODE_KERNEL 2'h0
`define PEV_FPE_W 6
`define PEV_FCS_STAT_LSB 52
`define PEV_FCS_TEN_LSB 0
`define PEV_LINK_SLOT 3'h7

// ***********************************************
// exception type codes
// ***********************************************
`define PEV_EXC_DTBM_DBL3 4'h0
`define PEV_EXC_DTBM_DBL4 4'h1
`define PEV_EXC_FP_OFF 4'h2
`define PEV_EXC_MISALIGN 4'h3
`define PEV_EXC_DTBM_SINGLE 4'h4
`define PEV_EXC_DATA_FLT 4'h5
`define PEV_EXC_ILL_OPC 4'h6
`define PEV_EXC_INSTR_ACV 4'h7
`define PEV_EXC_MACH_CHK 4'h8
`define PEV_EXC_INSTR_MISS 4'h9
`define PEV_EXC_MATH 4'ha
`define PEV_EXC_INTR 4'hb
`define PEV_EXC_FCS_WRITE 4'hc
`define PEV_EXC_RESET 4'hd

// ***********************************************
// entry offsets from the firmware base
// ***********************************************
`define PEV_ENT_DTBM_DBL3 15'h0100
`define PEV_ENT_DTBM_DBL4 15'h0180
`define PEV_ENT_FP_OFF 15'h0200
`define PEV_ENT_MISALIGN 15'h0280
`define PEV_ENT_DTBM_SINGLE 15'h0300
`define PEV_ENT_DATA_FLT 15'h0380
`define PEV_ENT_ILL_OPC 15'h0400
`define PEV_ENT_INSTR_ACV 15'h0480
`define PEV_ENT_MACH_CHK 15'h0500
`define PEV_ENT_INSTR_MISS 15'h0580
`define PEV_ENT_MATH 15'h0600
`define PEV_ENT_INTR 15'h0680
`define PEV_ENT_FCS_WRITE 15'h0700
`define PEV_ENT_RESET 15'h0780
`define PEV_ENT_CALL_PRIV 15'h2000
`define PEV_ENT_CALL_UNPRIV 15'h3000

`endif

/* File: hdl/pev_core.v */
// privileged firmware entry vectoring, shadow registers, fp control
// What this block does
// - privileged mode with shadow bit 1 set maps eight shadows on R4-7, R20-23
// - privileged call writes next instruction address into shadow R23
// - linkage bit 0 set when call came from privileged mode
// - call acts as jump: one bubble cycle, then fetch from entry
// - privileged call pushes return address onto return prediction stack
// - privileged calls enter at offset 2000, unprivileged at 3000
// - call code 40-7F or above BF goes to illegal opcode entry
// - call code 00-3F outside kernel mode goes to illegal opcode entry
// - legal call entry keeps base bits 63:15, bit 14 zero, bit 13 one
// - entry bit 12 from code bit 7, bits 11:6 from code 5:0, bit 0 one
// - exception stores return address and pushes it on prediction stack
// - exception redirects fetch to base plus offset chosen by type
// - pte fetch miss to 100 or 180, plain data miss to 300
// - fp disabled 200, unaligned 280, data fault 380
// - illegal opcodes and formats go to 400
// - instruction access violation 480, instruction miss 580
// - machine check 500, interrupts 680, reset or wake 780
// - arithmetic trap 600, fp control write issue traps to 700
// - fp exception traps when status bit clear or trap enabled
// - fp control write loads first latch, second latch at retire
// - the write traps to its own entry at the same edge that loads the first latch
// - fp control read is served straight from the visible latch
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`include "pev_regs.vh"

module pev_core #(
	parameter [63:0] BASE_RESET = `PEV_BASE_RESET
) (
	// clock and reset
	input wire i_core_clk,
	input wire i_reset_n,
	// register port
	input wire [`PEV_ADDR_W-1:0] i_reg_addr,
	input wire [63:0] i_reg_wdata,
	input wire i_reg_wr,
	input wire i_reg_rd,
	output reg [63:0] o_reg_rdata,
	// privileged call from fetch
	input wire i_call_valid,
	input wire [63:0] i_call_pc,
	input wire [7:0] i_call_func,
	// exception and trap events
	input wire i_exc_valid,
	input wire [3:0] i_exc_type,
	input wire [63:0] i_evt_pc,
	input wire i_op_valid,
	input wire [5:0] i_opcode,
	input wire i_ext_prec,
	input wire i_unimpl_func,
	input wire i_fpe_valid,
	input wire [`PEV_FPE_W-1:0] i_fpe_bits,
	// fp control write and firmware return
	input wire i_fpcw_issue,
	input wire [63:0] i_fpcw_data,
	input wire i_fpcw_retire,
	input wire i_fw_ret_valid,
	input wire [63:0] i_fw_ret_pc,
	// integer register overlay
	input wire [4:0] i_sh_rd_idx,
	input wire i_sh_wr_en,
	input wire [4:0] i_sh_wr_idx,
	input wire [63:0] i_sh_wr_data,
	output wire o_sh_rd_hit,
	output wire o_sh_wr_hit,
	output reg [63:0] o_sh_rd_data,
	// fetch redirect and prediction stack
	output reg o_fetch_bubble,
	output reg o_redirect_valid,
	output reg [63:0] o_redirect_pc,
	output reg o_ras_push,
	output reg [63:0] o_ras_addr,
	// visible state
	output wire o_priv_mode,
	output wire [63:0] o_fcs_value
);

	// ***********************************************
	// functions
	// ***********************************************
	// returns {hit, slot}; slot = {idx[4], idx[1:0]}
	function [3:0] shadow_map;
		input en;
		input [4:0] idx;
		begin
			shadow_map = {en & (idx[3:2] == 2'b01),
				idx[4], idx[1:0]};
		end
	endfunction

	function [14:0] exc_offset;
		input [3:0] t;
		begin
			case (t)
			`PEV_EXC_DTBM_DBL3: exc_offset = `PEV_ENT_DTBM_DBL3;
			`PEV_EXC_DTBM_DBL4: exc_offset = `PEV_ENT_DTBM_DBL4;
			`PEV_EXC_DTBM_SINGLE: exc_offset = `PEV_ENT_DTBM_SINGLE;
			`PEV_EXC_FP_OFF: exc_offset = `PEV_ENT_FP_OFF;
			`PEV_EXC_MISALIGN: exc_offset = `PEV_ENT_MISALIGN;
			`PEV_EXC_DATA_FLT: exc_offset = `PEV_ENT_DATA_FLT;
			`PEV_EXC_ILL_OPC: exc_offset = `PEV_ENT_ILL_OPC;
			`PEV_EXC_INSTR_ACV: exc_offset = `PEV_ENT_INSTR_ACV;
			`PEV_EXC_INSTR_MISS: exc_offset = `PEV_ENT_INSTR_MISS;
			`PEV_EXC_MACH_CHK: exc_offset = `PEV_ENT_MACH_CHK;
			`PEV_EXC_INTR: exc_offset = `PEV_ENT_INTR;
			`PEV_EXC_RESET: exc_offset = `PEV_ENT_RESET;
			`PEV_EXC_MATH: exc_offset = `PEV_ENT_MATH;
			`PEV_EXC_FCS_WRITE: exc_offset = `PEV_ENT_FCS_WRITE;
			default: exc_offset = `PEV_ENT_ILL_OPC;
			endcase
		end
	endfunction

	// ***********************************************
	// state
	// ***********************************************
	reg [63:0] base_reg;
	reg [2:0] fetch_ctl_reg;
	reg [1:0] mode_reg;
	reg priv_reg;
	reg reset_pend_reg;
	reg [63:0] exc_addr_reg;
	reg [63:0] fcs_first_reg;
	reg [63:0] fcs_vis_reg;
	reg call_pend_reg;
	reg [63:0] call_tgt_reg;
	reg [63:0] call_ret_reg;
	reg [14:0] last_off_reg;
	reg [63:0] shadow_mem [0:7];

	wire shadow_bit = fetch_ctl_reg[`PEV_CTL_SHADOW_BIT];
	wire hw_instr_en = fetch_ctl_reg[`PEV_CTL_HWINSTR_BIT];
	wire sh_en = priv_reg & shadow_bit;
	wire [3:0] rd_map = shadow_map(sh_en, i_sh_rd_idx);
	wire [3:0] wr_map = shadow_map(sh_en, i_sh_wr_idx);

	assign o_sh_rd_hit = rd_map[3];
	assign o_sh_wr_hit = wr_map[3];
	assign o_priv_mode = priv_reg;
	assign o_fcs_value = fcs_vis_reg;

	// ***********************************************
	// event decode
	// ***********************************************
	wire [1:0] fhi = i_call_func[7:6];
	// codes 40-7f and c0-ff are never callable
	wire call_bad = (fhi == 2'b01) | (fhi == 2'b11) |
		((fhi == 2'b00) & (mode_reg != `PEV_MODE_KERNEL));
	wire call_ok = i_call_valid & ~call_bad;
	wire call_ill = i_call_valid & call_bad;

	wire op_hw = (i_opcode == 6'h19) | (i_opcode == 6'h1b) |
		(i_opcode == 6'h1d) | (i_opcode == 6'h1e) |
		(i_opcode == 6'h1f);
	wire op_ill = i_op_valid & (((i_opcode >= 6'h01) &
		(i_opcode <= 6'h07)) | (op_hw & ~(priv_reg & hw_instr_en)) |
		i_ext_prec | i_unimpl_func);

	wire [`PEV_FPE_W-1:0] fp_stat =
		fcs_vis_reg[`PEV_FCS_STAT_LSB +: `PEV_FPE_W];
	wire [`PEV_FPE_W-1:0] fp_ten =
		fcs_vis_reg[`PEV_FCS_TEN_LSB +: `PEV_FPE_W];
	// a clear status bit also traps so firmware can record it
	wire fpe_trap = i_fpe_valid &
		(|(i_fpe_bits & (~fp_stat | fp_ten)));

	// one vector per cycle; only the pending reset vector takes precedence over external exceptions
	reg evt;
	reg [3:0] evt_type;
	always @* begin
		evt = 1'b1;
		evt_type = `PEV_EXC_ILL_OPC;
		if (reset_pend_reg) begin
			evt_type = `PEV_EXC_RESET;
		end else if (i_exc_valid) begin
			evt_type = i_exc_type;
		end else if (fpe_trap) begin
			evt_type = `PEV_EXC_MATH;
		end else if (i_fpcw_issue) begin
			evt_type = `PEV_EXC_FCS_WRITE;
		end else if (op_ill | call_ill) begin
			evt_type = `PEV_EXC_ILL_OPC;
		end else begin
			evt = 1'b0;
		end
	end

	wire [14:0] evt_off = exc_offset(evt_type);
	wire [63:0] evt_entry = {base_reg[63:15], evt_off[14:1],
		1'b1};
	wire [63:0] call_entry = {base_reg[63:15], 1'b0, 1'b1,
		i_call_func[7], i_call_func[5:0], 5'h00, 1'b1};
	wire [63:0] call_next = i_call_pc + 64'h0000000000000004;

	// ***********************************************
	// vectoring and mode
	// ***********************************************
	always @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			reset_pend_reg <= 1'b1;
			priv_reg <= 1'b1;
			exc_addr_reg <= 64'h0000000000000000;
			call_pend_reg <= 1'b0;
			call_tgt_reg <= 64'h0000000000000000;
			call_ret_reg <= 64'h0000000000000000;
			last_off_reg <= 15'h0000;
			o_fetch_bubble <= 1'b0;
			o_redirect_valid <= 1'b0;
			o_redirect_pc <= 64'h0000000000000000;
			o_ras_push <= 1'b0;
			o_ras_addr <= 64'h0000000000000000;
		end else begin
			reset_pend_reg <= 1'b0;
			o_fetch_bubble <= 1'b0;
			o_redirect_valid <= 1'b0;
			o_ras_push <= 1'b0;
			call_pend_reg <= 1'b0;
			if (i_fw_ret_valid) begin
				priv_reg <= i_fw_ret_pc[0];
			end
			if (evt) begin
				// a trap in the bubble cycle kills the pending call
				o_redirect_valid <= 1'b1;
				o_redirect_pc <= evt_entry;
				last_off_reg <= evt_off;
				priv_reg <= 1'b1;
				if (!reset_pend_reg) begin
					exc_addr_reg <= i_evt_pc;
					o_ras_push <= 1'b1;
					o_ras_addr <= i_evt_pc;
				end
				if (call_ill & ~reset_pend_reg & ~i_exc_valid &
					~fpe_trap & ~i_fpcw_issue & ~op_ill) begin
					exc_addr_reg <= i_call_pc;
					o_ras_addr <= i_call_pc;
				end
			end else if (call_pend_reg) begin
				o_redirect_valid <= 1'b1;
				o_redirect_pc <= call_tgt_reg;
				last_off_reg <= call_tgt_reg[14:0];
				priv_reg <= 1'b1;
			end else if (call_ok) begin
				// jump without abort: bubble now, redirect next
				call_pend_reg <= 1'b1;
				call_tgt_reg <= call_entry;
				call_ret_reg <= {call_next[63:1],
					priv_reg};
				o_fetch_bubble <= 1'b1;
				o_ras_push <= 1'b1;
				o_ras_addr <= call_next;
			end
		end
	end

	// ***********************************************
	// shadow scratch registers
	// ***********************************************
	// the linkage write wins over a same-cycle pipeline write to R23
	wire link_we = call_ok & ~evt & ~call_pend_reg;
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_sh
			always @(posedge i_core_clk or negedge i_reset_n) begin
				if (!i_reset_n) begin
					shadow_mem[g] <= 64'h0000000000000000;
				end else if (link_we &&
					(g == `PEV_LINK_SLOT)) begin
					shadow_mem[g] <= {call_next[63:1],
						priv_reg};
				end else if (i_sh_wr_en && wr_map[3] &&
					(wr_map[2:0] == g)) begin
					shadow_mem[g] <= i_sh_wr_data;
				end
			end
		end
	endgenerate

	always @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_sh_rd_data <= 64'h0000000000000000;
		end else begin
			o_sh_rd_data <= rd_map[3] ?
				shadow_mem[rd_map[2:0]] : 64'h0000000000000000;
		end
	end

	// ***********************************************
	// floating-point control latches
	// ***********************************************
	always @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			fcs_first_reg <= `PEV_FCS_RESET;
			fcs_vis_reg <= `PEV_FCS_RESET;
		end else begin
			// the first latch reaches readers only through the register port at PEV_OFF_FCS_FIRST
			if (i_fpcw_issue) begin
				fcs_first_reg <= i_fpcw_data;
			end
			// no scoreboard here; firmware orders readers
			// same-cycle issue and retire forwards the new value
			if (i_fpcw_retire) begin
				fcs_vis_reg <= i_fpcw_issue ?
					i_fpcw_data : fcs_first_reg;
			end
		end
	end

	// ***********************************************
	// register port
	// ***********************************************
	// unmapped and read-only offsets ignore writes
	always @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			base_reg <= BASE_RESET;
			fetch_ctl_reg <= 3'h0;
			mode_reg <= `PEV_MODE_KERNEL;
		end else if (i_reg_wr) begin
			case (i_reg_addr)
			`PEV_OFF_BASE: begin
				base_reg <= i_reg_wdata;
			end
			`PEV_OFF_FETCH_CTL: begin
				fetch_ctl_reg <= i_reg_wdata[2:0];
			end
			`PEV_OFF_MODE: begin
				mode_reg <= i_reg_wdata[1:0];
			end
			default: ;
			endcase
		end
	end

	always @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_reg_rdata <= 64'h0000000000000000;
		end else if (i_reg_rd) begin
			case (i_reg_addr)
			`PEV_OFF_BASE: begin
				o_reg_rdata <= base_reg;
			end
			`PEV_OFF_FETCH_CTL: begin
				o_reg_rdata <= {61'h0, fetch_ctl_reg};
			end
			`PEV_OFF_MODE: begin
				o_reg_rdata <= {62'h0, mode_reg};
			end
			`PEV_OFF_FCS_VIS: begin
				o_reg_rdata <= fcs_vis_reg;
			end
			`PEV_OFF_FCS_FIRST: begin
				o_reg_rdata <= fcs_first_reg;
			end
			`PEV_OFF_EXC_ADDR: begin
				o_reg_rdata <= exc_addr_reg;
			end
			`PEV_OFF_STATUS: begin
				o_reg_rdata <= {32'h0, 1'b0,
					last_off_reg, 14'h0,
					call_pend_reg, priv_reg};
			end
			default: begin
				o_reg_rdata <= 64'h0000000000000000;
			end
			endcase
		end else begin
			o_reg_rdata <= 64'h0000000000000000;
		end
	end

endmodule // pev_core

/* File: sim/pev_core_checker.sv */
// port assertions for the privileged entry vectoring block
`timescale 1ns/100ps
module pev_core_checker (
	// clock, reset and events
	input wire i_core_clk,
	input wire i_reset_n,
	input wire i_call_valid,
	input wire [63:0] i_call_pc,
	input wire [7:0] i_call_func,
	input wire i_exc_valid,
	input wire [3:0] i_exc_type,
	input wire [63:0] i_evt_pc,
	input wire i_op_valid,
	input wire [5:0] i_opcode,
	input wire i_fpe_valid,
	input wire i_fpcw_issue,
	input wire [63:0] i_fpcw_data,
	input wire i_fpcw_retire,
	input wire [4:0] i_sh_rd_idx,
	// block outputs
	input wire o_sh_rd_hit,
	input wire o_fetch_bubble,
	input wire o_redirect_valid,
	input wire [63:0] o_redirect_pc,
	input wire o_ras_push,
	input wire [63:0] o_ras_addr,
	input wire o_priv_mode,
	input wire [63:0] o_fcs_value
);
// events on the first edge after reset lose to the reset vector
reg [1:0] up_reg;
wire up = up_reg[1];
wire quiet = up && !i_exc_valid && !i_fpe_valid && !i_fpcw_issue;
always @(posedge i_core_clk or negedge i_reset_n) begin
	if (!i_reset_n)
		up_reg <= 2'h0;
	else if (!up_reg[1])
		up_reg <= up_reg + 2'h1;
end
default clocking cb @(posedge i_core_clk); endclocking
default disable iff (!i_reset_n);
// ********************
// assertions
// ********************
property p_exc_entry;
	up && i_exc_valid |=> o_redirect_valid &&
		o_redirect_pc[14:0] == {4'h0, $past(i_exc_type), 7'h0} + 15'h0101;
endproperty
a_exc_entry: assert property (p_exc_entry)
	else $error("exception entry wrong");
property p_exc_ras;
	up && i_exc_valid |=> o_ras_push && o_ras_addr == $past(i_evt_pc);
endproperty
a_exc_ras: assert property (p_exc_ras)
	else $error("exception return address wrong");
property p_call;
	quiet && i_call_valid && i_call_func[7:6] == 2'h2 |=> o_fetch_bubble &&
		!o_redirect_valid && o_ras_push &&
		o_ras_addr == $past(i_call_pc) + 64'h4 ##1 o_redirect_valid &&
		o_redirect_pc[14:0] == {2'h1, $past(i_call_func[7], 2),
		$past(i_call_func[5:0], 2), 6'h01};
endproperty
a_call: assert property (p_call)
	else $error("call entry wrong");
property p_call_bad;
	quiet && i_call_valid && i_call_func[6] |=> o_redirect_valid &&
		!o_fetch_bubble && o_redirect_pc[14:0] == 15'h0401;
endproperty
a_call_bad: assert property (p_call_bad)
	else $error("illegal call not diverted");
property p_opc;
	quiet && !i_call_valid && i_op_valid && i_opcode != 6'h00 &&
		i_opcode[5:3] == 3'h0 |=> o_redirect_valid &&
		o_redirect_pc[14:0] == 15'h0401;
endproperty
a_opc: assert property (p_opc)
	else $error("illegal opcode not diverted");
property p_fpcw;
	up && i_fpcw_issue && !i_exc_valid && !i_fpe_valid |=>
		o_redirect_valid && o_redirect_pc[14:0] == 15'h0701;
endproperty
a_fpcw: assert property (p_fpcw)
	else $error("fp control write did not trap");
property p_fp_hold;
	up && !i_fpcw_retire |=> $stable(o_fcs_value);
endproperty
a_fp_hold: assert property (p_fp_hold)
	else $error("visible fp latch moved without retire");
property p_fp_both;
	up && i_fpcw_issue && i_fpcw_retire |=> o_fcs_value == $past(i_fpcw_data);
endproperty
a_fp_both: assert property (p_fp_both)
	else $error("visible fp latch missed retire");
property p_shadow;
	o_sh_rd_hit |-> o_priv_mode && i_sh_rd_idx[3:2] == 2'h1;
endproperty
a_shadow: assert property (p_shadow)
	else $error("shadow hit outside overlay");
c_call: cover property (quiet && i_call_valid);
c_fp: cover property (i_fpcw_issue && i_fpcw_retire);
c_hit: cover property (o_sh_rd_hit);
endmodule // pev_core_checker

/* File: sim/pev_fetch_model.sv */
// fetch side model: follows redirects and prediction stack pushes
`timescale 1ns/100ps
module pev_fetch_model (
	// clock and reset
	input wire i_core_clk,
	input wire i_reset_n,
	// from the vectoring block
	input wire i_redirect_valid,
	input wire [63:0] i_redirect_pc,
	input wire i_ras_push,
	input wire [63:0] i_ras_addr,
	// fetch state for the bench
	output reg [63:0] o_fetch_pc,
	output reg [63:0] o_ras_top,
	output reg [31:0] o_n_redir
);
// only the top of stack is kept: the bench checks one push at a time
always @(posedge i_core_clk or negedge i_reset_n) begin
	if (!i_reset_n) begin
		o_fetch_pc <= 64'h0;
		o_ras_top <= 64'h0;
		o_n_redir <= 32'h0;
	end else begin
		if (i_redirect_valid) begin
			o_fetch_pc <= i_redirect_pc;
			o_n_redir <= o_n_redir + 32'h1;
		end
		if (i_ras_push)
			o_ras_top <= i_ras_addr;
	end
end
endmodule // pev_fetch_model

/* File: sim/pev_testbench.sv */
// self-checking bench for the privileged entry vectoring block
`timescale 1ns/100ps
`include "pev_regs.vh"
module testbench;
// ********************
// stimulus and observation
// ********************
localparam [63:0] BR = 64'hfedcba9876548000;
localparam [71:0] FNS = 72'h9a_ff_c0_bf_80_7f_40_3f_00;
localparam [23:0] OPS = {6'h19, 6'h00, 6'h19, 6'h03};
reg i_core_clk = 1'h0, i_reset_n = 1'h0, i_reg_wr = 1'h0, i_reg_rd = 1'h0;
reg i_call_valid = 1'h0, i_exc_valid = 1'h0, i_op_valid = 1'h0;
reg i_ext_prec = 1'h0, i_fpe_valid = 1'h0, i_fpcw_issue = 1'h0;
reg i_fpcw_retire = 1'h0, i_fw_ret_valid = 1'h0;
reg [7:0] i_reg_addr = 8'h00, i_call_func = 8'h00;
reg [3:0] i_exc_type = 4'h0;
reg [5:0] i_opcode = 6'h00, i_fpe_bits = 6'h00;
reg [4:0] i_sh_rd_idx = 5'h17;
reg [63:0] i_reg_wdata = 64'h0, i_call_pc = 64'h0, i_evt_pc = 64'h0;
reg [63:0] i_fpcw_data = 64'h0, i_fw_ret_pc = 64'h0;
wire [63:0] o_reg_rdata, o_sh_rd_data, o_redirect_pc, o_ras_addr;
wire [63:0] o_fcs_value, fetch_pc, ras_top;
wire o_sh_rd_hit, o_sh_wr_hit, o_fetch_bubble, o_redirect_valid;
wire o_ras_push, o_priv_mode;
wire [31:0] n_redir;
integer err_total = 0, n_compared = 0, seed = 19, k;
reg [63:0] base, pc, v, d;
reg [31:0] r0;
reg [7:0] f;
// shadow write port tied: the overlay is watched through the call linkage
pev_core #(.BASE_RESET(BR)) dut (.*, .i_unimpl_func(1'h0),
	.i_sh_wr_en(1'h0), .i_sh_wr_idx(5'h00), .i_sh_wr_data(64'h0));
pev_fetch_model fm (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
	.i_redirect_valid(o_redirect_valid), .i_redirect_pc(o_redirect_pc),
	.i_ras_push(o_ras_push), .i_ras_addr(o_ras_addr),
	.o_fetch_pc(fetch_pc), .o_ras_top(ras_top), .o_n_redir(n_redir));
initial forever #50 i_core_clk = ~i_core_clk;
// ********************
// tasks
// ********************
task chk(input string nm, input [63:0] e, input [63:0] g);
	n_compared = n_compared + 1;
	if (g !== e) begin
		$display("ERROR %s expected %h seen %h", nm, e, g);
		err_total = err_total + 1;
	end
endtask
task final_report;
	$display("compared %0d mismatched %0d", n_compared, err_total);
	if (err_total == 0 && n_compared > 0)
		$display("Simulation passed");
	else
		$display("Simulation failed");
	$finish;
endtask
task idle(input integer n);
	repeat (n) @(posedge i_core_clk);
endtask
task fin;
	@(posedge i_core_clk);
	{i_reg_wr, i_reg_rd, i_call_valid, i_exc_valid, i_op_valid} <= 5'h0;
	{i_fpe_valid, i_fpcw_issue, i_fpcw_retire, i_fw_ret_valid} <= 4'h0;
	i_ext_prec <= 1'h0;
endtask
task wr(input [7:0] a, input [63:0] x);
	@(posedge i_core_clk);
	i_reg_addr <= a;
	i_reg_wdata <= x;
	i_reg_wr <= 1'h1;
	fin;
endtask
task rd(input [7:0] a, output [63:0] q);
	@(posedge i_core_clk);
	i_reg_addr <= a;
	i_reg_rd <= 1'h1;
	fin;
	#1;
	q = o_reg_rdata;
endtask
function [63:0] ent(input [14:0] off);
	ent = {base[63:15], off} | 64'h1;
endfunction
task ev_end(input [31:0] r, input [31:0] n, input [14:0] off);
	idle(3);
	chk("redirects", {32'h0, r + n}, {32'h0, n_redir});
	if (n != 32'h0)
		chk("entry", ent(off), fetch_pc);
endtask
task call(input [7:0] fn);
	@(posedge i_core_clk);
	pc = {$random(seed), $random(seed)} & ~64'h3;
	i_call_valid <= 1'h1;
	i_call_pc <= pc;
	i_call_func <= fn;
	fin;
	idle(3);
endtask
task fpe(input [5:0] b, input [31:0] n);
	r0 = n_redir;
	@(posedge i_core_clk);
	i_fpe_valid <= 1'h1;
	i_fpe_bits <= b;
	fin;
	ev_end(r0, n, 15'h0600);
endtask
// ********************
// main sequence
// ********************
initial begin
	idle(16);
	i_reset_n <= 1'h1;
	idle(4);
	base = BR;
	chk("reset entry", ent(15'h0780), fetch_pc);
	rd(`PEV_OFF_STATUS, v);
	chk("status", {33'h0, 15'h0780, 16'h1}, v);
	base = {$random(seed), $random(seed)};
	wr(`PEV_OFF_BASE, base);
	rd(`PEV_OFF_BASE, v);
	chk("base", base, v);
	rd(8'h38, v);
	chk("unmapped", 64'h0, v);
	wr(`PEV_OFF_FETCH_CTL, 64'h2);
	wr(`PEV_OFF_MODE, 64'h0);
	for (k = 0; k < 14; k = k + 1) begin
		r0 = n_redir;
		@(posedge i_core_clk);
		pc = {$random(seed), $random(seed)};
		i_exc_valid <= 1'h1;
		i_exc_type <= k[3:0];
		i_evt_pc <= pc;
		fin;
		ev_end(r0, 1, {k[3:0], 7'h0} + 15'h0100);
		chk("ras", pc, ras_top);
	end
	wr(`PEV_OFF_EXC_ADDR, ~pc);
	rd(`PEV_OFF_EXC_ADDR, v);
	chk("exc addr", pc, v);
	for (k = 0; k < 9; k = k + 1) begin
		f = FNS[8*k +: 8];
		if (!k[0]) begin
			@(posedge i_core_clk);
			i_fw_ret_pc <= 64'h1000;
			i_fw_ret_valid <= 1'h1;
			fin;
			idle(1);
			chk("hidden", 64'h0, {63'h0, o_sh_rd_hit});
		end
		call(f);
		if (f[6]) begin
			chk("bad call", ent(15'h0400), fetch_pc);
			chk("bad ras", pc, ras_top);
		end else begin
			chk("call", {base[63:15], 2'h1, f[7], f[5:0], 6'h01}, fetch_pc);
			chk("call ras", pc + 64'h4, ras_top);
			chk("hit", 64'h1, {63'h0, o_sh_rd_hit});
			d = pc + 64'h4;
			chk("link", {d[63:1], k[0]}, o_sh_rd_data);
		end
	end
	wr(`PEV_OFF_MODE, 64'h1);
	call(8'h05);
	chk("user call", ent(15'h0400), fetch_pc);
	for (k = 0; k < 4; k = k + 1) begin
		if (k == 3)
			wr(`PEV_OFF_FETCH_CTL, 64'h6);
		r0 = n_redir;
		@(posedge i_core_clk);
		i_op_valid <= 1'h1;
		i_opcode <= OPS[6*k +: 6];
		i_ext_prec <= (k == 2);
		fin;
		ev_end(r0, {31'h0, k < 3}, 15'h0400);
	end
	d = 64'h0010000000000000;
	r0 = n_redir;
	@(posedge i_core_clk);
	i_fpcw_issue <= 1'h1;
	i_fpcw_data <= d;
	fin;
	ev_end(r0, 1, 15'h0700);
	chk("fp early", 64'h0, o_fcs_value);
	rd(`PEV_OFF_FCS_FIRST, v);
	chk("fp first", d, v);
	fpe(6'h01, 1);
	@(posedge i_core_clk);
	i_fpcw_retire <= 1'h1;
	fin;
	idle(2);
	chk("fp retire", d, o_fcs_value);
	rd(`PEV_OFF_FCS_VIS, v);
	chk("fp read", d, v);
	fpe(6'h01, 0);
	fpe(6'h02, 1);
	d = {$random(seed), $random(seed)};
	@(posedge i_core_clk);
	{i_fpcw_issue, i_fpcw_retire} <= 2'h3;
	i_fpcw_data <= d;
	fin;
	idle(2);
	chk("fp both", d, o_fcs_value);
	final_report;
end
initial begin
	repeat (20000) @(posedge i_core_clk);
	$display("ERROR watchdog expected end seen hang");
	err_total = err_total + 1;
	final_report;
end
endmodule // testbench
bind pev_core pev_core_checker chk_i (.*);
